// [inc/pmc_defs.svh]
// constants for the global power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_CLK_PERIOD_NS 100
`define PMC_SLEEP_WAKE_NS 25000
`define PMC_HIB_WAKE_NS 200000
// cycles that fit strictly inside each wake time
`define PMC_SLEEP_WAKE_MAX ((`PMC_SLEEP_WAKE_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_HIB_WAKE_MAX ((`PMC_HIB_WAKE_NS - 1) / `PMC_CLK_PERIOD_NS)
// two sync stages, entry to waking and exit to active lie outside the count
`define PMC_WAKE_LAT_CYC 4
`define PMC_SLEEP_WAKE_CYC (`PMC_SLEEP_WAKE_MAX - `PMC_WAKE_LAT_CYC)
`define PMC_HIB_WAKE_CYC (`PMC_HIB_WAKE_MAX - `PMC_WAKE_LAT_CYC)
`define PMC_CNT_W 12
`define PMC_REQ_ACTIVE 2'h0
`define PMC_REQ_ALT 2'h1
`define PMC_REQ_SLEEP 2'h2
`define PMC_REQ_HIB 2'h3
`define PMC_SUBSYS_W 8
`define PMC_SUB_CPU 0
`define PMC_SUB_I2C 1
`define PMC_SUB_CMP 2
`define PMC_TPL_RESET 8'hff
`endif

// [inc/pmc_pkg.sv]
// types for the global power mode controller
`default_nettype none
package pmc_pkg;
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'h0,
        PMC_ALT = 3'h1,
        PMC_SLEEP = 3'h3,
        PMC_HIB = 3'h2,
        PMC_WAKE = 3'h6
    } pmc_mode_e;

    typedef struct packed {
        logic comparator;
        logic port_interrupt_unit;
        logic i2c;
        logic rtc;
        logic central_timewheel;
        logic low_voltage_detect;
    } pmc_wake_s;

    typedef struct packed {
        logic external_reset_pin;
        logic low_voltage_detect;
        logic watchdog_reset;
    } pmc_rst_s;

    typedef struct packed {
        logic [1:0] req;
        logic req_wr;
        logic regs_off;
    } pmc_ctl_s;
endpackage
`default_nettype wire

// [rtl/pmc_sync.sv]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

// [rtl/pmc_ctrl.sv]
// global power mode controller: mode select, gating, wake and reset qualify
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_ctrl
    import pmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pmc_ctl_s ctl_i,
    input wire logic [`PMC_SUBSYS_W-1:0] act_tpl_i,
    input wire logic [`PMC_SUBSYS_W-1:0] alt_tpl_i,
    input wire logic irq_i,
    input wire pmc_wake_s wake_pin_i,
    input wire pmc_rst_s rst_pin_i,
    output logic [2:0] mode_o,
    output logic [`PMC_SUBSYS_W-1:0] sub_en_o,
    output logic fast_clk_en_o,
    output logic slow_clk_en_o,
    output logic core_reg_en_o,
    output logic sys_reset_o,
    output logic wake_o
);
    typedef struct packed {
        pmc_mode_e mode;
        logic [`PMC_CNT_W-1:0] cnt;
        logic [`PMC_SUBSYS_W-1:0] sub_en;
        logic fast_clk;
        logic slow_clk;
        logic core_reg;
        logic sys_reset;
        logic wake;
        logic cpu_force;
        logic wr_q;
    } pmc_state_s;

    pmc_state_s s_q;
    pmc_state_s s_d;
    pmc_wake_s wk;
    pmc_rst_s rs;
    logic wake_hit;
    logic reset_hit;
    logic [`PMC_SUBSYS_W-1:0] tpl;
    logic [`PMC_SUBSYS_W-1:0] keep_sleep;

    // pins arrive from other domains; irq_i is already on clk_i
    pmc_sync #(.W(6)) u_wake_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(wake_pin_i),
        .q_o(wk)
    );
    pmc_sync #(.W(3)) u_rst_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(rst_pin_i),
        .q_o(rs)
    );

    always_comb begin
        keep_sleep = '0;
        keep_sleep[`PMC_SUB_I2C] = 1'b1;
        keep_sleep[`PMC_SUB_CMP] = 1'b1;
        // qualified wake and reset sources per mode
        wake_hit = 1'b0;
        reset_hit = 1'b0;
        case (s_q.mode)
            PMC_ACTIVE, PMC_ALT: begin
                wake_hit = irq_i;
                reset_hit = |rs;
            end
            PMC_SLEEP: begin
                wake_hit = |wk;
                reset_hit = |rs;
            end
            PMC_HIB: begin
                wake_hit = wk.port_interrupt_unit;
                reset_hit = rs.external_reset_pin;
            end
            default: begin
                // waking already: only resets still count
                wake_hit = 1'b0;
                reset_hit = |rs;
            end
        endcase
    end

    always_comb begin
        s_d = s_q;
        // both pulses drop after one cycle unless their source is still qualified
        s_d.wake = 1'b0;
        s_d.sys_reset = 1'b0;
        // register write completes one cycle before acting
        s_d.wr_q = ctl_i.req_wr;
        if (reset_hit) begin
            // a qualified source restarts in active, not a block reset
            s_d.mode = PMC_ACTIVE;
            s_d.sys_reset = 1'b1;
            s_d.cpu_force = 1'b0;
            s_d.cnt = '0;
        end else begin
            case (s_q.mode)
                PMC_ACTIVE, PMC_ALT: begin
                    if (s_q.mode == PMC_ALT && wake_hit) begin
                        s_d.mode = PMC_ACTIVE;
                        s_d.cpu_force = 1'b1;
                        s_d.wake = 1'b1;
                    end else if (s_q.wr_q) begin
                        s_d.cpu_force = 1'b0;
                        case (ctl_i.req)
                            `PMC_REQ_ACTIVE: s_d.mode = PMC_ACTIVE;
                            `PMC_REQ_ALT: s_d.mode = PMC_ALT;
                            `PMC_REQ_SLEEP: s_d.mode = PMC_SLEEP;
                            default: s_d.mode = PMC_HIB;
                        endcase
                    end else if (wake_hit) begin
                        s_d.cpu_force = 1'b1;
                        s_d.wake = 1'b1;
                    end
                end
                PMC_SLEEP: begin
                    if (wake_hit) begin
                        // count leaves room for the synchroniser delay
                        s_d.mode = PMC_WAKE;
                        s_d.cnt = `PMC_CNT_W'(`PMC_SLEEP_WAKE_CYC);
                    end
                end
                PMC_HIB: begin
                    if (wake_hit) begin
                        s_d.mode = PMC_WAKE;
                        // only the port interrupt unit gets here
                        s_d.cnt = `PMC_CNT_W'(`PMC_HIB_WAKE_CYC);
                    end
                end
                PMC_WAKE: begin
                    // settle regulators before releasing gates
                    if (s_q.cnt == '0) begin
                        s_d.mode = PMC_ACTIVE;
                        s_d.cpu_force = 1'b1;
                        s_d.wake = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt - 1'b1;
                    end
                end
                default: s_d.mode = PMC_ACTIVE;
            endcase
        end
        // regulator clear honoured only in the active modes
        if (s_q.mode == PMC_ACTIVE || s_q.mode == PMC_ALT) begin
            s_d.core_reg = ~ctl_i.regs_off;
        end
        // template follows the mode being entered, so a wake
        // never spends a cycle on the wrong template
        if (s_d.mode == PMC_ALT) begin
            tpl = alt_tpl_i;
        end else begin
            tpl = act_tpl_i;
        end
        // cpu comes back whatever its template bit says
        if (s_d.cpu_force) begin
            tpl[`PMC_SUB_CPU] = 1'b1;
        end
        // low power modes override whatever the templates ask for
        case (s_d.mode)
            PMC_ACTIVE, PMC_ALT: begin
                s_d.sub_en = tpl;
                s_d.fast_clk = 1'b1;
                s_d.slow_clk = 1'b1;
            end
            PMC_SLEEP: begin
                s_d.sub_en = keep_sleep;
                s_d.fast_clk = 1'b0;
                s_d.slow_clk = 1'b1;
            end
            default: begin
                s_d.sub_en = '0;
                s_d.fast_clk = 1'b0;
                s_d.slow_clk = 1'b0;
            end
        endcase
        if (s_q.mode == PMC_ACTIVE && s_d.mode == PMC_ACTIVE) begin
            s_d.sub_en = tpl;
        end
    end

    // synchronous reset puts the device in active with all on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.mode <= PMC_ACTIVE;
            s_q.sub_en <= `PMC_TPL_RESET;
            s_q.fast_clk <= 1'b1;
            s_q.slow_clk <= 1'b1;
            s_q.core_reg <= 1'b1;
            s_q.cpu_force <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // every output comes straight from a flip-flop
    assign mode_o = s_q.mode;
    assign sub_en_o = s_q.sub_en;
    assign fast_clk_en_o = s_q.fast_clk;
    assign slow_clk_en_o = s_q.slow_clk;
    assign core_reg_en_o = s_q.core_reg;
    assign sys_reset_o = s_q.sys_reset;
    assign wake_o = s_q.wake;
endmodule
`default_nettype wire

// [test/pmc_ctrl_props.sv]
// concurrent checks on the power mode controller ports
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_props
    import pmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pmc_ctl_s ctl_i,
    input wire logic [7:0] act_tpl_i,
    input wire logic [7:0] alt_tpl_i,
    input wire logic irq_i,
    input wire pmc_wake_s wake_pin_i,
    input wire pmc_rst_s rst_pin_i,
    input wire logic [2:0] mode_o,
    input wire logic [7:0] sub_en_o,
    input wire logic fast_clk_en_o,
    input wire logic slow_clk_en_o,
    input wire logic core_reg_en_o,
    input wire logic sys_reset_o,
    input wire logic wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // wake from hibernate outlasts any delay range, so count it here
    logic [2:0] prev_mode_q;
    logic from_hib_q;
    logic [11:0] hib_cyc_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_mode_q <= 3'h0;
            from_hib_q <= 1'b0;
            hib_cyc_q <= 12'h000;
        end else begin
            prev_mode_q <= mode_o;
            from_hib_q <= mode_o == PMC_WAKE &&
                (from_hib_q || prev_mode_q == PMC_HIB);
            if (mode_o == PMC_WAKE) begin
                hib_cyc_q <= hib_cyc_q + 12'h001;
            end else begin
                hib_cyc_q <= 12'h000;
            end
        end
    end
    sequence sleep_req;
        ctl_i.req_wr && mode_o == PMC_ACTIVE ##1 ctl_i.req == 2'h2;
    endsequence
    sequence waking_from(logic [2:0] m);
        $rose(mode_o == PMC_WAKE) && $past(mode_o) == m;
    endsequence
    req_sleep_a: assert property (sleep_req |=> mode_o == PMC_SLEEP)
        else $error("sleep request not taken");
    sleep_gate_a: assert property (mode_o == PMC_SLEEP |->
        sub_en_o == 8'h06 && !fast_clk_en_o && slow_clk_en_o)
        else $error("sleep gating wrong");
    hib_gate_a: assert property (mode_o == PMC_HIB |->
        sub_en_o == 8'h00 && !fast_clk_en_o && !slow_clk_en_o)
        else $error("hibernate gating wrong");
    wake_cpu_a: assert property (wake_o |->
        mode_o == PMC_ACTIVE && sub_en_o[0])
        else $error("wake without active cpu");
    act_tpl_a: assert property (mode_o == PMC_ACTIVE && !$past(rst_i) &&
        $past(mode_o) == PMC_ACTIVE |-> sub_en_o[7:1] == $past(act_tpl_i[7:1]))
        else $error("active template not applied");
    sleep_wake_a: assert property (waking_from(PMC_SLEEP) |->
        ##[1:246] mode_o == PMC_ACTIVE)
        else $error("sleep wake too slow");
    hib_wake_a: assert property (from_hib_q |->
        hib_cyc_q <= 12'h7cc &&
        (mode_o == PMC_WAKE || mode_o == PMC_ACTIVE))
        else $error("hibernate wake too slow");
    hib_hold_a: assert property ((mode_o == PMC_HIB &&
        !wake_pin_i.port_interrupt_unit &&
        !rst_pin_i.external_reset_pin)[*4] |=> mode_o == PMC_HIB)
        else $error("hibernate left without pin event");
    regs_off_a: assert property (mode_o == PMC_ACTIVE &&
        ctl_i.regs_off |=> !core_reg_en_o)
        else $error("regulator enable not cleared");
    regs_hold_a: assert property (mode_o != PMC_ACTIVE &&
        mode_o != PMC_ALT |=> $stable(core_reg_en_o))
        else $error("regulator enable changed in low power");
endmodule
`default_nettype wire

// [test/power_mode_controller_tb.sv]
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module power_mode_controller_tb
    import pmc_pkg::*;
;
    logic clk_i = 0, rst_i = 1, irq_i = 0;
    pmc_ctl_s ctl = '0;
    pmc_wake_s wk = '0;
    pmc_rst_s rp = '0;
    logic [7:0] act = 8'hff, alt = 8'h00, sub_en;
    logic [2:0] mode;
    logic fck, sck, creg, srst, wake;
    logic [31:0] s = 32'h26;
    int mismatches = 0, n_tests = 0, cyc = 0, n;
    always #50 clk_i = ~clk_i;
    pmc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ctl_i(ctl),
        .act_tpl_i(act), .alt_tpl_i(alt), .irq_i(irq_i), .wake_pin_i(wk),
        .rst_pin_i(rp), .mode_o(mode), .sub_en_o(sub_en),
        .fast_clk_en_o(fck), .slow_clk_en_o(sck), .core_reg_en_o(creg),
        .sys_reset_o(srst), .wake_o(wake));
    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // low power modes ignore the template
    function automatic logic [7:0] exp_en(logic [2:0] m, logic [7:0] t);
        return m == PMC_SLEEP ? 8'h06 : m == PMC_HIB ? 8'h00 : t;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // req is held past the strobe since it is read one edge later
    task automatic req(input logic [1:0] r);
        @(posedge clk_i);
        ctl.req <= r;
        ctl.req_wr <= 1'b1;
        @(posedge clk_i);
        ctl.req_wr <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wt(input bit rs, input int lim);
        n = 0;
        while (n < lim && (rs ? srst : wake) !== 1'b1) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({mode, sub_en, fck, sck, creg}, {3'h0, 8'hff, 3'h7});
        repeat (4) begin
            @(posedge clk_i);
            act <= 8'(xs());
            ctl.regs_off <= 1'b1;
            repeat (2) @(posedge clk_i);
            #1;
            chk(sub_en[7:1], act[7:1]);
        end
        chk(creg, 1'b0);
        @(posedge clk_i);
        alt <= 8'(xs());
        req(2'h1);
        chk({mode, sub_en}, {PMC_ALT, alt});
        @(posedge clk_i);
        irq_i <= 1'b1;
        wt(1'b0, 20);
        chk(mode, PMC_ACTIVE);
        @(posedge clk_i);
        irq_i <= 1'b0;
        // six wake sources, then the three sleep reset sources
        for (int k = 0; k < 9; k++) begin
            req(2'h2);
            chk({mode, sub_en, fck},
                {PMC_SLEEP, exp_en(PMC_SLEEP, act), 1'b0});
            @(posedge clk_i);
            if (k < 6) wk <= pmc_wake_s'(6'h01 << k);
            else rp <= pmc_rst_s'(3'h1 << (k - 6));
            wt(k > 5, 300);
            chk(n < `PMC_SLEEP_WAKE_NS / `PMC_CLK_PERIOD_NS, 1'b1);
            @(posedge clk_i);
            wk <= '0;
            rp <= '0;
            repeat (2) @(posedge clk_i);
            #1;
            chk(mode, PMC_ACTIVE);
        end
        req(2'h3);
        chk({mode, sub_en, fck, sck},
            {PMC_HIB, exp_en(PMC_HIB, act), 2'b0});
        @(posedge clk_i);
        wk <= pmc_wake_s'(6'h2f);
        rp <= pmc_rst_s'(3'h3);
        irq_i <= 1'b1;
        ctl <= '{req: 2'h0, req_wr: 1'b1, regs_off: 1'b1};
        wt(1'b1, 10);
        chk({n[3:0], mode}, {4'ha, PMC_HIB});
        @(posedge clk_i);
        ctl.req_wr <= 1'b0;
        irq_i <= 1'b0;
        rp <= '0;
        wk <= pmc_wake_s'(6'h10);
        wt(1'b0, 2100);
        chk({n < `PMC_HIB_WAKE_NS / `PMC_CLK_PERIOD_NS, sub_en[0]},
            2'b11);
        test_done();
    end
endmodule
bind pmc_ctrl pmc_ctrl_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .ctl_i(ctl_i), .act_tpl_i(act_tpl_i), .alt_tpl_i(alt_tpl_i),
    .irq_i(irq_i), .wake_pin_i(wake_pin_i), .rst_pin_i(rst_pin_i),
    .mode_o(mode_o), .sub_en_o(sub_en_o), .fast_clk_en_o(fast_clk_en_o),
    .slow_clk_en_o(slow_clk_en_o), .core_reg_en_o(core_reg_en_o),
    .sys_reset_o(sys_reset_o), .wake_o(wake_o));
`default_nettype wire
